/* File: bench/bps_panel_model.sv */
// Far-side model of the sequencer: breath clock, sync oscillator and effort pins
`timescale 1ns/100ps

module bps_panel_model (
  input  wire logic clk,
  output logic      clk_pulse_in,
  output logic      sync_osc_in,
  output logic      patient_trig_in
);
  initial begin
    clk_pulse_in = 1'b0;
    sync_osc_in = 1'b0;
    patient_trig_in = 1'b0;
  end

  // **************************************************
  // Pin pulses: 0 clock, 1 sync oscillator, 2 effort
  // **************************************************
  // Four idle cycles after each pulse keep the edges resolvable
  task automatic pulse_pin(input int which, input int n);
    repeat (n) begin
      @(posedge clk);
      case (which)
        0: clk_pulse_in <= 1'b1;
        1: sync_osc_in <= 1'b1;
        default: patient_trig_in <= 1'b1;
      endcase
      repeat (2) @(posedge clk);
      clk_pulse_in <= 1'b0;
      sync_osc_in <= 1'b0;
      patient_trig_in <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule

/* File: bench/tb.sv */
// Self-checking bench of the breath-phase sequencer
`timescale 1ns/100ps
`include "bps_defs.svh"

module tb;
  import bps_pkg::*;
  logic        clk;
  logic        rst_b;
  logic [7:0]  addr;
  logic [31:0] wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rd_data;
  logic [11:0] pins;
  logic        ck_p;
  logic        sy_p;
  logic        tr_p;
  logic        insp_time;
  logic        exp_time;
  logic        pls;
  logic        spont;
  logic        forced_breath;
  logic        sync_start;
  logic        startup_clear;
  logic        cycle_clear;
  logic [12:0] mode_signals;
  logic [31:0] d;
  int          err_total = 0;
  int          compares = 0;
  int          n_st = 0;
  int          n_cc = 0;
  int          n_fb = 0;
  int          n_sy = 0;
  int          n_ex = 0;
  logic [7:0]  ra [6] = '{`BPS_REG_MODE, `BPS_REG_CTRL, `BPS_REG_INSP, `BPS_REG_PAUSE,
                          `BPS_REG_RATE, 8'h18};
  logic [31:0] rv [6] = '{{29'h0, `BPS_MODE_RST}, 32'h0, {25'h0, `BPS_INSP_RST},
                          {25'h0, `BPS_PAUSE_RST}, {16'h0, `BPS_SYNC_RST, `BPS_MAIN_RST}, 32'h0};

  bps_top bps_top_i (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .clk_pulse_in(ck_p), .sync_osc_in(sy_p),
    .patient_trig_in(tr_p), .upper_press_in(pins[0]), .high_insp_press_in(pins[1]),
    .flow_low_in(pins[2]), .flow_peak_in(pins[3]), .valve_closed_in(pins[4]),
    .press_rise_in(pins[5]), .p_below2_in(pins[6]), .p_above4_in(pins[7]),
    .p_above6_in(pins[8]), .insp_hold_in(pins[9]), .exp_hold_in(pins[10]),
    .gas_change_in(pins[11]), .insp_time(insp_time), .exp_time(exp_time),
    .pressure_loop_select(pls), .spontaneous_exhale_start(spont),
    .forced_breath(forced_breath), .sync_period_start(sync_start),
    .startup_clear(startup_clear), .cycle_clear(cycle_clear), .mode_signals(mode_signals)
  );

  bps_panel_model bps_panel_model_i (
    .clk(clk), .clk_pulse_in(ck_p), .sync_osc_in(sy_p), .patient_trig_in(tr_p)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Pulses are one cycle wide, so one count per high sample
  always @(posedge clk) begin
    n_st <= n_st + 32'(startup_clear === 1'b1);
    n_cc <= n_cc + 32'(cycle_clear === 1'b1);
    n_fb <= n_fb + 32'(forced_breath === 1'b1);
    n_sy <= n_sy + 32'(sync_start === 1'b1);
    n_ex <= n_ex + 32'(spont === 1'b1);
  end

  // **************************************************
  // Bus, pin and check tasks
  // **************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    v = rd_data;
  endtask

  // Pin inputs pass two synchroniser stages and an edge stage
  task automatic settle;
    repeat (8) @(posedge clk);
    #1;
  endtask

  task automatic set_pins(input logic [11:0] v);
    @(posedge clk);
    pins <= v;
    settle;
  endtask

  task automatic pulse(input int which, input int n);
    bps_panel_model_i.pulse_pin(which, n);
    settle;
  endtask

  task automatic set_mode(input bps_mode_t m);
    wr(`BPS_REG_MODE, {29'h0, m});
    settle;
  endtask

  task automatic tally_and_finish;
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    tally_and_finish;
  end

  // **************************************************
  // Main sequence
  // **************************************************
  initial begin
    {rst_b, addr, wr_data, wr_en, rd_en, pins} = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    settle;
    check("power_on_clear", 32'(n_st), 32'h1);
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], d);
      check("reset_value", d, rv[i]);
    end
    wr(`BPS_REG_RATE, 32'h00000a0f);
    rd(`BPS_REG_RATE, d);
    check("rate_rw", d, 32'h00000a0f);
    set_mode(M_PC);
    check("mode_clear", 32'(n_st), 32'h2);
    check("cycle_clear", 32'(n_cc), 32'h1);
    check("exp_now", 32'(exp_time), 32'h1);
    check("pc_decode", 32'(mode_signals[3]), 32'h1);
    pulse(0, 99);
    check("forced_exp_99", 32'(insp_time), 32'h0);
    pulse(0, 1);
    check("insp_at_100", 32'(insp_time), 32'h1);
    pulse(0, 24);
    check("insp_24", 32'(insp_time), 32'h1);
    pulse(0, 1);
    check("insp_end_25", 32'(insp_time), 32'h0);
    pulse(0, 10);
    check("exp_after_pause", 32'(exp_time), 32'h1);
    pulse(2, 1);
    check("effort_insp", 32'(insp_time), 32'h1);
    set_pins(12'h001);
    check("upper_end", 32'(insp_time), 32'h0);
    set_pins(12'h000);
    pulse(2, 1);
    check("effort_insp2", 32'(insp_time), 32'h1);
    set_pins(12'h002);
    check("high_press_end", 32'(insp_time), 32'h0);
    set_pins(12'h800);
    set_pins(12'h000);
    check("gas_clear", 32'(n_st), 32'h3);
    check("gas_cycle_clear", 32'(n_cc), 32'h2);
    // Manual: bag comparators alone decide the phases
    set_mode(M_MAN);
    check("man_decode", 32'(mode_signals[11]), 32'h1);
    set_pins(12'h040);
    check("bag_fill", 32'(insp_time), 32'h1);
    set_pins(12'h080);
    check("bag_stop", 32'(insp_time), 32'h0);
    set_pins(12'h000);
    check("man_exp", 32'(exp_time), 32'h1);
    set_pins(12'h180);
    check("man_exp_stop", 32'(exp_time), 32'h0);
    pulse(0, 100);
    check("auto_cut", 32'(insp_time), 32'h0);
    check("auto_cut_exp", 32'(exp_time), 32'h0);
    set_pins(12'h000);
    check("man_exp_again", 32'(exp_time), 32'h1);
    // Pressure support: end of spontaneous inspiration
    set_mode(M_PS);
    check("ps_decode", 32'(mode_signals[2]), 32'h1);
    pulse(2, 1);
    check("ps_insp", 32'(insp_time), 32'h1);
    set_pins(12'h00c);
    check("flow_drop", 32'(n_ex), 32'h1);
    check("ps_insp_end", 32'(insp_time), 32'h0);
    set_pins(12'h000);
    pulse(2, 1);
    set_pins(12'h004);
    check("no_peak", 32'(n_ex), 32'h1);
    set_pins(12'h030);
    check("valve_rise", 32'(n_ex), 32'h2);
    set_pins(12'h000);
    // Synchronized periods and wait interval
    set_mode(M_SIMV);
    check("simv_decode", 32'(mode_signals[7]), 32'h1);
    pulse(2, 1);
    check("press_loop", 32'(pls), 32'h1);
    set_pins(12'h030);
    check("simv_exhale", 32'(n_ex), 32'h3);
    set_pins(12'h000);
    pulse(1, 99);
    check("sync_99", 32'(n_sy), 32'h0);
    pulse(1, 1);
    check("sync_100", 32'(n_sy), 32'h1);
    pulse(0, 89);
    check("wait_89", 32'(n_fb), 32'h0);
    pulse(0, 1);
    check("wait_90", 32'(n_fb), 32'h1);
    pulse(0, 40);
    pulse(1, 100);
    check("sync_200", 32'(n_sy), 32'h2);
    pulse(2, 1);
    check("effort_ends_wait", 32'(n_fb), 32'h2);
    wr(`BPS_REG_CTRL, 32'h1);
    pulse(1, 1000);
    check("low_range", 32'(n_sy), 32'h3);
    // Override, pause hold and the 81 percent limit
    set_mode(M_SIMVPS);
    check("simvps_decode", 32'(mode_signals[6]), 32'h1);
    wr(`BPS_REG_RATE, 32'h0000100f);
    pulse(0, 99);
    check("ovr_99", 32'(n_sy), 32'h3);
    pulse(0, 1);
    check("ovr_100", 32'(n_sy), 32'h4);
    pulse(2, 1);
    check("mand_trig", 32'(n_fb), 32'h3);
    set_pins(12'h200);
    pulse(0, 30);
    check("insp_held", 32'(insp_time), 32'h1);
    check("flow_loop", 32'(pls), 32'h0);
    set_pins(12'h000);
    pulse(0, 1);
    check("hold_release", 32'(insp_time), 32'h0);
    set_mode(M_VC);
    check("vc_decode", 32'(mode_signals[5]), 32'h1);
    wr(`BPS_REG_INSP, 32'h5a);
    pulse(0, 180);
    check("limit_80", 32'(insp_time), 32'h1);
    pulse(0, 1);
    check("limit_81", 32'(insp_time), 32'h0);
    tally_and_finish;
  end
endmodule

/* File: logic/bps_defs.svh */
// Offsets, field positions, reset values and pulse counts of the breath-phase sequencer
`ifndef BPS_DEFS_SVH
`define BPS_DEFS_SVH

`define BPS_REG_MODE     8'h00
`define BPS_REG_CTRL     8'h04
`define BPS_REG_INSP     8'h08
`define BPS_REG_PAUSE    8'h0c
`define BPS_REG_RATE     8'h10
`define BPS_REG_STAT     8'h14

`define BPS_CTRL_LOWRATE 0
`define BPS_RATE_MAIN_LO 0
`define BPS_RATE_SYNC_LO 8

`define BPS_MODE_RST     3'h1
`define BPS_INSP_RST     7'h19
`define BPS_PAUSE_RST    7'h0a
`define BPS_MAIN_RST     8'h0f
`define BPS_SYNC_RST     8'h05

`define BPS_CYCLE_LAST   7'h63
`define BPS_SYNC_DIV_LAST 7'h63
`define BPS_LOW_DIV_LAST 4'h9
`define BPS_WAIT_LAST    7'h59
`define BPS_LIMIT_LAST   7'h50
`define BPS_FEXP_LAST    7'h63

`define BPS_PIN_N        15
`define BPS_PIN_CLK      0
`define BPS_PIN_SYNC     1
`define BPS_PIN_TRIG     2
`define BPS_PIN_UPPER    3
`define BPS_PIN_HIGHP    4
`define BPS_PIN_FLOWLOW  5
`define BPS_PIN_PEAK     6
`define BPS_PIN_VCLOSED  7
`define BPS_PIN_PRISE    8
`define BPS_PIN_PBELOW2  9
`define BPS_PIN_PABOVE4  10
`define BPS_PIN_PABOVE6  11
`define BPS_PIN_IHOLD    12
`define BPS_PIN_EHOLD    13
`define BPS_PIN_GAS      14

`endif

/* File: logic/bps_pkg.sv */
// Types of the breath-phase sequencer
package bps_pkg;

  typedef enum logic [2:0] {
    M_PC     = 3'h0,
    M_VC     = 3'h1,
    M_VSIGH  = 3'h2,
    M_PS     = 3'h3,
    M_SIMV   = 3'h4,
    M_SIMVPS = 3'h5,
    M_CONTINUOUS_PRESSURE_MODE   = 3'h6,
    M_MAN    = 3'h7
  } bps_mode_t;

  typedef enum logic [2:0] {
    PH_INSP  = 3'b001,
    PH_PAUSE = 3'b010,
    PH_EXP   = 3'b100
  } bps_phase_t;

endpackage

/* File: logic/bps_top.sv */
// Breath-phase sequencer: phase clock, sync period timing, mode decode, manual timing
// What this block does
// - Manual mode routes bag-driven timing to phase outputs, automatic generator disconnected.
// - Either pause-hold button withholds phase clock pulses, inspiration hold at end of inspiration, expiration hold at a cycle boundary.
// - Sync oscillator divided by 100, and by 10 more in low-rate range.
// - Sync generator emits exactly one period-start pulse per sync period.
// - Period start begins wait; ends on patient effort or after 90 main pulses.
// - Wait end, either way, fires the forced-breath trigger for mandatory inspiration.
// - Spontaneous breaths in sync modes assert pressure-loop select.
// - When sync rate exceeds main rate, the main rate governs breaths.
// - Mode selector decodes into 13 mode signals.
// - Start-up clear pulse on mode change, power-on and gas change.
// - Mode or gas change gives cycle-clear pulse and immediate expiration.
// - That forced expiration lasts 100 pulses unless patient effort ends it.
// - End-of-inspiration detector works in all spontaneous modes, issuing exhale start.
// - Exhale start when flow below quarter of peak, if peak exceeded 0.1 l/s.
// - Exhale start also when valve closed and pressure rose 3 cm H2O.
// - Manual bag fill starts below 2 cm H2O, stops above 4.
// - Manual expiration starts below 4 cm H2O, stops above 6.
// - Pressure control inspiration starts from rate timing or patient effort.
// - Pressure control inspiration ends on time count or upper pressure limit.
// - Pressure control inspiration also ends on high inspiratory pressure comparator.
// - Controlled expiration ends on every 100th pulse or patient effort.
// - Outside continuous, manual, spontaneous: expiration forced at 81 percent of cycle.
`timescale 1ns/100ps
`include "bps_defs.svh"

module bps_top
  import bps_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rd_data,
  input  wire logic        clk_pulse_in,
  input  wire logic        sync_osc_in,
  input  wire logic        patient_trig_in,
  input  wire logic        upper_press_in,
  input  wire logic        high_insp_press_in,
  input  wire logic        flow_low_in,
  input  wire logic        flow_peak_in,
  input  wire logic        valve_closed_in,
  input  wire logic        press_rise_in,
  input  wire logic        p_below2_in,
  input  wire logic        p_above4_in,
  input  wire logic        p_above6_in,
  input  wire logic        insp_hold_in,
  input  wire logic        exp_hold_in,
  input  wire logic        gas_change_in,
  output logic             insp_time,
  output logic             exp_time,
  output logic             pressure_loop_select,
  output logic             spontaneous_exhale_start,
  output logic             forced_breath,
  output logic             sync_period_start,
  output logic             startup_clear,
  output logic             cycle_clear,
  output logic      [12:0] mode_signals
);

  // ******************************
  // Pin synchronisers
  // ******************************
  logic [`BPS_PIN_N-1:0] pin_raw;
  logic [`BPS_PIN_N-1:0] pin_meta_q;
  logic [`BPS_PIN_N-1:0] pin_q;
  logic [`BPS_PIN_N-1:0] pin_prev_q;

  assign pin_raw = {gas_change_in, exp_hold_in, insp_hold_in, p_above6_in, p_above4_in,
                    p_below2_in, press_rise_in, valve_closed_in, flow_peak_in, flow_low_in,
                    high_insp_press_in, upper_press_in, patient_trig_in, sync_osc_in,
                    clk_pulse_in};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta_q <= '0;
      pin_q      <= '0;
      pin_prev_q <= '0;
    end else begin
      pin_meta_q <= pin_raw;
      pin_q      <= pin_meta_q;
      pin_prev_q <= pin_q;
    end
  end

  logic clk_rise;
  logic sync_rise;
  logic trig_rise;
  logic gas_rise;
  assign clk_rise  = pin_q[`BPS_PIN_CLK] & ~pin_prev_q[`BPS_PIN_CLK];
  assign sync_rise = pin_q[`BPS_PIN_SYNC] & ~pin_prev_q[`BPS_PIN_SYNC];
  assign trig_rise = pin_q[`BPS_PIN_TRIG] & ~pin_prev_q[`BPS_PIN_TRIG];
  assign gas_rise  = pin_q[`BPS_PIN_GAS] & ~pin_prev_q[`BPS_PIN_GAS];

  // ******************************
  // Registers
  // ******************************
  bps_mode_t  mode_q;
  logic       low_rate_q;
  logic [6:0] insp_cnt_q;
  logic [6:0] pause_cnt_q;
  logic [7:0] rate_main_q;
  logic [7:0] rate_sync_q;
  logic       mode_chg;
  logic       por_q;
  bps_phase_t phase_q;
  logic       fexp_q;
  logic       wait_q;

  assign mode_chg = wr_en && (addr == `BPS_REG_MODE) && (wr_data[2:0] != mode_q);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q      <= bps_mode_t'(`BPS_MODE_RST);
      low_rate_q  <= 1'b0;
      insp_cnt_q  <= `BPS_INSP_RST;
      pause_cnt_q <= `BPS_PAUSE_RST;
      rate_main_q <= `BPS_MAIN_RST;
      rate_sync_q <= `BPS_SYNC_RST;
    end else if (wr_en) begin
      case (addr)
        `BPS_REG_MODE:  mode_q      <= bps_mode_t'(wr_data[2:0]);
        `BPS_REG_CTRL:  low_rate_q  <= wr_data[`BPS_CTRL_LOWRATE];
        `BPS_REG_INSP:  insp_cnt_q  <= wr_data[6:0];
        `BPS_REG_PAUSE: pause_cnt_q <= wr_data[6:0];
        `BPS_REG_RATE: begin
          rate_main_q <= wr_data[`BPS_RATE_MAIN_LO +: 8];
          rate_sync_q <= wr_data[`BPS_RATE_SYNC_LO +: 8];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= '0;
    end else if (rd_en) begin
      case (addr)
        `BPS_REG_MODE:  rd_data <= {29'h0, mode_q};
        `BPS_REG_CTRL:  rd_data <= {31'h0, low_rate_q};
        `BPS_REG_INSP:  rd_data <= {25'h0, insp_cnt_q};
        `BPS_REG_PAUSE: rd_data <= {25'h0, pause_cnt_q};
        `BPS_REG_RATE:  rd_data <= {16'h0, rate_sync_q, rate_main_q};
        `BPS_REG_STAT:  rd_data <= {3'h0, mode_signals, 11'h0, wait_q, fexp_q, phase_q};
        default:        rd_data <= '0;
      endcase
    end else begin
      rd_data <= '0;
    end
  end

  // ******************************
  // Mode decode
  // ******************************
  logic is_man;
  logic is_simv;
  logic spont_mode;
  logic ctrl_mode;
  logic lim_mode;
  logic override;
  logic mand_q;
  assign is_man     = (mode_q == M_MAN);
  assign is_simv    = (mode_q == M_SIMV) || (mode_q == M_SIMVPS);
  assign spont_mode = is_simv || (mode_q == M_PS) || (mode_q == M_CONTINUOUS_PRESSURE_MODE);
  assign ctrl_mode  = (mode_q == M_PC) || (mode_q == M_VC) || (mode_q == M_VSIGH);
  // Spontaneous breaths have no time limit; mandatory ones in sync modes do
  assign lim_mode   = !is_man && (mode_q != M_CONTINUOUS_PRESSURE_MODE) && (!spont_mode || mand_q);
  // Sync rate above main rate: main breath timing drives the periods instead
  assign override   = rate_sync_q > rate_main_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_signals <= '0;
    end else begin
      mode_signals <= {mode_chg,
                       is_man,
                       is_simv || (mode_q == M_CONTINUOUS_PRESSURE_MODE),
                       mode_q == M_CONTINUOUS_PRESSURE_MODE,
                       is_simv,
                       mode_q == M_SIMV,
                       mode_q == M_SIMVPS,
                       mode_q == M_VC,
                       mode_q == M_VSIGH,
                       mode_q == M_PC,
                       mode_q == M_PS,
                       spont_mode && !mand_q,
                       spont_mode && !mand_q && (phase_q == PH_INSP)};
    end
  end

  // ******************************
  // Clear pulses
  // ******************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      por_q         <= 1'b1;
      startup_clear <= 1'b0;
      cycle_clear   <= 1'b0;
    end else begin
      por_q         <= 1'b0;
      startup_clear <= por_q || mode_chg || gas_rise;
      cycle_clear   <= mode_chg || gas_rise;
    end
  end

  // ******************************
  // Pause hold and phase clock
  // ******************************
  logic [6:0] cnt_q;
  logic [7:0] pause_end;
  logic       insp_done;
  logic       hold_hit;
  logic       freeze_q;
  logic       tick;
  assign pause_end = {1'b0, insp_cnt_q} + {1'b0, pause_cnt_q};
  assign insp_done = ({1'b0, cnt_q} + 8'h01) >= {1'b0, insp_cnt_q};
  // Freeze only at the end of a phase so the breath is never cut mid-phase
  assign hold_hit  = clk_rise && !is_man &&
                     ((pin_q[`BPS_PIN_IHOLD] && phase_q == PH_INSP && insp_done) ||
                      (pin_q[`BPS_PIN_EHOLD] && phase_q == PH_EXP &&
                       cnt_q == `BPS_CYCLE_LAST));
  assign tick      = clk_rise && !freeze_q && !hold_hit;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      freeze_q <= 1'b0;
    end else if (!pin_q[`BPS_PIN_IHOLD] && !pin_q[`BPS_PIN_EHOLD]) begin
      freeze_q <= 1'b0;
    end else if (hold_hit) begin
      freeze_q <= 1'b1;
    end
  end

  // ******************************
  // Sync period generator and wait
  // ******************************
  logic [6:0] div_q;
  logic [3:0] div10_q;
  logic [6:0] wait_cnt_q;
  logic       period_d;
  logic       wait_end;

  always_comb begin
    period_d = 1'b0;
    if (is_simv) begin
      if (override) begin
        period_d = tick && (cnt_q == `BPS_CYCLE_LAST);
      end else if (sync_rise && div_q == `BPS_SYNC_DIV_LAST) begin
        period_d = !low_rate_q || (div10_q == `BPS_LOW_DIV_LAST);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q   <= '0;
      div10_q <= '0;
    end else if (sync_rise) begin
      div_q <= (div_q == `BPS_SYNC_DIV_LAST) ? 7'h00 : div_q + 7'h01;
      if (div_q == `BPS_SYNC_DIV_LAST) begin
        div10_q <= (div10_q == `BPS_LOW_DIV_LAST || !low_rate_q) ? 4'h0 : div10_q + 4'h1;
      end
    end
  end

  assign wait_end = wait_q && (trig_rise ||
                               (tick && wait_cnt_q == `BPS_WAIT_LAST));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q            <= 1'b0;
      wait_cnt_q        <= '0;
      sync_period_start <= 1'b0;
      forced_breath     <= 1'b0;
    end else begin
      sync_period_start <= period_d;
      forced_breath     <= wait_end && is_simv;
      if (!is_simv || mode_chg) begin
        wait_q     <= 1'b0;
        wait_cnt_q <= '0;
      end else if (period_d) begin
        wait_q     <= 1'b1;
        wait_cnt_q <= '0;
      end else if (wait_end) begin
        wait_q <= 1'b0;
      end else if (wait_q && tick) begin
        wait_cnt_q <= wait_cnt_q + 7'h01;
      end
    end
  end

  // ******************************
  // End-of-inspiration detector
  // ******************************
  logic peak_seen_q;
  logic exhale_d;
  assign exhale_d = spont_mode && !mand_q && phase_q == PH_INSP &&
                    ((pin_q[`BPS_PIN_FLOWLOW] && peak_seen_q) ||
                     (pin_q[`BPS_PIN_VCLOSED] && pin_q[`BPS_PIN_PRISE]));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      peak_seen_q              <= 1'b0;
      spontaneous_exhale_start <= 1'b0;
    end else begin
      spontaneous_exhale_start <= exhale_d;
      if (phase_q != PH_INSP) begin
        peak_seen_q <= 1'b0;
      end else if (pin_q[`BPS_PIN_PEAK]) begin
        peak_seen_q <= 1'b1;
      end
    end
  end

  // ******************************
  // Automatic phase generator
  // ******************************
  logic [6:0] fexp_cnt_q;
  logic       start_insp;
  logic       start_mand;
  logic       end_to_exp;

  always_comb begin
    start_mand = 1'b0;
    start_insp = 1'b0;
    if (phase_q == PH_EXP && !is_man) begin
      if (is_simv) begin
        start_mand = wait_end;
        start_insp = wait_end || (trig_rise && !wait_q);
      end else if (ctrl_mode) begin
        start_mand = (trig_rise || (tick && !fexp_q && cnt_q == `BPS_CYCLE_LAST) ||
                      (fexp_q && tick && fexp_cnt_q == `BPS_FEXP_LAST));
        start_insp = start_mand;
      end else begin
        start_insp = trig_rise;
      end
    end
  end

  assign end_to_exp = (phase_q == PH_INSP) &&
                      (pin_q[`BPS_PIN_UPPER] ||
                       (mode_q == M_PC && pin_q[`BPS_PIN_HIGHP]) ||
                       exhale_d ||
                       (lim_mode && tick && cnt_q == `BPS_LIMIT_LAST));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q    <= PH_EXP;
      cnt_q      <= '0;
      mand_q     <= 1'b0;
      fexp_q     <= 1'b0;
      fexp_cnt_q <= '0;
    end else if (mode_chg || gas_rise) begin
      phase_q    <= PH_EXP;
      cnt_q      <= '0;
      mand_q     <= 1'b0;
      fexp_q     <= 1'b1;
      fexp_cnt_q <= '0;
    end else begin
      case (phase_q)
        PH_INSP: begin
          if (end_to_exp) begin
            phase_q <= PH_EXP;
          end else if (tick) begin
            cnt_q <= cnt_q + 7'h01;
            if (insp_done && (ctrl_mode || mand_q)) begin
              phase_q <= PH_PAUSE;
            end
          end
        end
        PH_PAUSE: begin
          if (pin_q[`BPS_PIN_UPPER]) begin
            phase_q <= PH_EXP;
          end else if (tick) begin
            cnt_q <= cnt_q + 7'h01;
            if (({1'b0, cnt_q} + 8'h01) >= pause_end) begin
              phase_q <= PH_EXP;
            end
          end
        end
        PH_EXP: begin
          if (start_insp) begin
            phase_q <= PH_INSP;
            cnt_q   <= '0;
            mand_q  <= start_mand;
            fexp_q  <= 1'b0;
          end else if (tick) begin
            cnt_q <= (cnt_q == `BPS_CYCLE_LAST) ? 7'h00 : cnt_q + 7'h01;
            if (fexp_q) begin
              fexp_cnt_q <= fexp_cnt_q + 7'h01;
              fexp_q     <= (fexp_cnt_q != `BPS_FEXP_LAST);
            end
          end
        end
        default: phase_q <= PH_EXP;
      endcase
    end
  end

  // ******************************
  // Manual timing and output multiplexer
  // ******************************
  logic man_insp_q;
  logic man_exp_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      man_insp_q <= 1'b0;
      man_exp_q  <= 1'b0;
    end else begin
      if (pin_q[`BPS_PIN_PABOVE4]) begin
        man_insp_q <= 1'b0;
      end else if (pin_q[`BPS_PIN_PBELOW2]) begin
        man_insp_q <= 1'b1;
      end
      if (pin_q[`BPS_PIN_PABOVE6]) begin
        man_exp_q <= 1'b0;
      end else if (!pin_q[`BPS_PIN_PABOVE4]) begin
        man_exp_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      insp_time            <= 1'b0;
      exp_time             <= 1'b0;
      pressure_loop_select <= 1'b0;
    end else begin
      insp_time            <= is_man ? man_insp_q : (phase_q == PH_INSP);
      exp_time             <= is_man ? man_exp_q : (phase_q == PH_EXP);
      pressure_loop_select <= !is_man && spont_mode && !mand_q && phase_q == PH_INSP;
    end
  end

  // ******************************
  // Checks
  // ******************************
  manual_mux_a: assert property (@(posedge clk) disable iff (!rst_b)
    is_man |=> insp_time == $past(man_insp_q) && exp_time == $past(man_exp_q))
    else $error("manual timing not routed to phase outputs");

  pause_freeze_a: assert property (@(posedge clk) disable iff (!rst_b)
    freeze_q && clk_rise && !start_insp && !mode_chg && !gas_rise |=> $stable(cnt_q))
    else $error("phase clock advanced during pause hold");

  sync_div_a: assert property (@(posedge clk) disable iff (!rst_b)
    (is_simv && !override && !low_rate_q && sync_rise && div_q == `BPS_SYNC_DIV_LAST)
    |=> sync_period_start)
    else $error("sync divider did not emit at its hundredth edge");

  single_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
    sync_period_start |=> !sync_period_start)
    else $error("period start longer than one cycle");

  wait_bound_a: assert property (@(posedge clk) disable iff (!rst_b)
    wait_q |-> wait_cnt_q <= `BPS_WAIT_LAST)
    else $error("wait interval ran past its limit");

  forced_trig_a: assert property (@(posedge clk) disable iff (!rst_b)
    (is_simv && wait_q && tick && wait_cnt_q == `BPS_WAIT_LAST)
    |=> forced_breath ##1 !forced_breath)
    else $error("forced breath missing at wait end");

  clear_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
    mode_chg |=> startup_clear && cycle_clear && phase_q == PH_EXP && fexp_q)
    else $error("mode change did not clear and force expiration");

  time_limit_a: assert property (@(posedge clk) disable iff (!rst_b)
    (phase_q == PH_INSP && lim_mode && tick && cnt_q == `BPS_LIMIT_LAST && !mode_chg &&
     !gas_rise) |=> phase_q == PH_EXP ##1 !insp_time || is_man)
    else $error("inspiration not limited");

endmodule
